/* File: shared/tsi_pkg.sv */
package tsi_pkg;

  // register indices; the bus byte address is four times the index
  localparam logic [7:0] EDGE_IDX = 8'hBF;
  localparam logic [7:0] FLAG_IDX = 8'hC8;
  localparam logic [7:0] EN_IDX = 8'hC9;
  localparam logic [7:0] STACK_POINTER_GLOBAL_ENABLE_IDX = 8'hDF;
  localparam logic [7:0] EVT_IDX = 8'hE0;
  localparam logic [7:0] MASK_IDX = 8'hE1;

  // source bit positions, shared by flag and enable registers
  localparam int EXT_BIT = 0;
  localparam int TA_BIT = 4;
  localparam int TB_BIT = 5;
  localparam logic [7:0] SRC_MASK = 8'h31;

  // stack pointer register layout
  localparam int GIE_BIT = 7;
  localparam logic [7:0] STACK_POINTER_GLOBAL_ENABLE_RESET = 8'h07;
  localparam logic [7:0] STACK_POINTER_GLOBAL_ENABLE_MASK = 8'h87;

  // edge select register layout and codes
  localparam int EDGE_LSB = 3;
  localparam logic [7:0] EDGE_RESET = 8'h10;
  localparam logic [7:0] EDGE_MASK = 8'h18;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // event status bits (sticky, write one to clear)
  localparam int EVT_TAKE = 0;
  localparam int EVT_WAKE = 1;
  localparam int EVT_RET = 2;
  localparam logic [7:0] EVT_MASK = 8'h07;

  // program counter
  localparam int PC_W = 10;
  localparam logic [9:0] VECTOR_PC = 10'h008;

  // bus
  localparam int ADDR_W = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef struct packed {
    logic boundary;
    logic [9:0] next_pc;
    logic return_from_irq;
  } tsi_core_in_type;

  typedef struct packed {
    logic take;
    logic [9:0] vec_pc;
    logic [9:0] ret_pc;
  } tsi_core_out_type;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_ACC = 2'h1,
    BUS_RESP = 2'h2
  } tsi_bus_state_type;

endpackage

/* File: design/tsi_edge_det.sv */
// synchronises the external pin and flags the selected edge
module tsi_edge_det (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin,
  input wire logic [1:0] sel,
  output logic evt
);

  logic sync1_q, sync1_d;
  logic sync2_q, sync2_d;
  logic prev_q, prev_d;
  logic rise, fall;

  // first stage feeds only the second; edge logic sees stages two and three
  always_comb begin
    sync1_d = pin;
    sync2_d = sync1_q;
    prev_d = sync2_q;
    rise = sync2_q & ~prev_q;
    fall = ~sync2_q & prev_q;
    case (sel)
      tsi_pkg::EDGE_RISE: evt = rise;
      tsi_pkg::EDGE_FALL: evt = fall;
      tsi_pkg::EDGE_BOTH: evt = rise | fall;
      default: evt = 1'b0; // reserved code never triggers
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q <= prev_d;
    end
  end

endmodule

/* File: design/tsi_unit.sv */
////////////////////////////////////////////////////////////////////////////
// How it works
// - three sources only: timer a overflow, timer b overflow, pin edge
// - taking an interrupt clears the global enable
// - leaving service sets the global enable again
// - return-from-interrupt ends service, restores enable, pops stack
// - taking an interrupt pushes one stack level and jumps to 8
// - vector only with global enable, source enable and flag all set
// - enable register: pin bit 0, timer a bit 4, timer b bit 5
// - flag register: pin bit 0, timer a bit 4, timer b bit 5
// - a selected pin edge sets the pin flag regardless of enable
// - timer a overflow sets its flag regardless of enable
// - disabled sources still flag but never cause a vector
// - timer b overflow sets its flag regardless of enable
// - global enable is stack register bit 7; level bits reset to 111
// - edge field bits 4:3: 01 rise, 10 fall, 11 both, reset 10
// - a pin event wakes the chip from power-down
module tsi_unit (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [11:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [11:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic timer_a_ovf,
  input wire logic timer_b_ovf,
  input wire logic ext_irq_pin,
  input wire logic power_down,
  input wire tsi_pkg::tsi_core_in_type core_in,
  output tsi_pkg::tsi_core_out_type core_out,
  output logic wake_req,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  tsi_pkg::tsi_bus_state_type wst_q, wst_d, rst_q, rst_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0] edge_q, edge_d, flag_q, flag_d, en_q, en_d;
  logic [7:0] stack_pointer_global_enable_q, stack_pointer_global_enable_d, evt_q, evt_d, mask_q, mask_d;
  tsi_pkg::tsi_core_out_type core_q, core_d;
  logic wake_q, wake_d, irq_q, irq_d;
  logic ext_evt, do_write, wr_hit, take;
  logic [7:0] wr_idx, wbyte, src_set, rd_val;
  logic [7:0] rd_idx;
  logic rd_hit;
  logic [2:0] stk_lvl;

  ////////////////////////////////////////////////////////////////////////////
  // external pin edge detection
  tsi_edge_det u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(ext_irq_pin),
    .sel(edge_q[tsi_pkg::EDGE_LSB +: 2]),
    .evt(ext_evt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data are taken together, then answered
  always_comb begin
    wst_d = wst_q;
    awready_d = 1'b0;
    wready_d = 1'b0;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    do_write = 1'b0;
    wr_idx = awaddr[9:2];
    wr_hit = 1'b0;
    if (awaddr[11:10] == 2'h0) begin
      case (wr_idx)
        tsi_pkg::EDGE_IDX, tsi_pkg::FLAG_IDX, tsi_pkg::EN_IDX,
        tsi_pkg::STACK_POINTER_GLOBAL_ENABLE_IDX, tsi_pkg::EVT_IDX, tsi_pkg::MASK_IDX:
          wr_hit = 1'b1;
        default: wr_hit = 1'b0;
      endcase
    end
    case (wst_q)
      tsi_pkg::BUS_IDLE: begin
        if (awvalid && wvalid) begin
          awready_d = 1'b1;
          wready_d = 1'b1;
          wst_d = tsi_pkg::BUS_ACC;
        end
      end
      tsi_pkg::BUS_ACC: begin
        do_write = wr_hit && wstrb[0]; // only the low lane holds data
        bvalid_d = 1'b1;
        bresp_d = wr_hit ? tsi_pkg::RESP_OKAY : tsi_pkg::RESP_DECERR;
        wst_d = tsi_pkg::BUS_RESP;
      end
      tsi_pkg::BUS_RESP: begin
        if (bready) begin
          bvalid_d = 1'b0;
          wst_d = tsi_pkg::BUS_IDLE;
        end
      end
      default: wst_d = tsi_pkg::BUS_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel and read data mux
  always_comb begin
    rst_d = rst_q;
    arready_d = 1'b0;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    rd_idx = araddr[9:2];
    rd_hit = araddr[11:10] == 2'h0;
    case (rd_idx)
      tsi_pkg::EDGE_IDX: rd_val = edge_q;
      tsi_pkg::FLAG_IDX: rd_val = flag_q;
      tsi_pkg::EN_IDX: rd_val = en_q;
      tsi_pkg::STACK_POINTER_GLOBAL_ENABLE_IDX: rd_val = stack_pointer_global_enable_q;
      tsi_pkg::EVT_IDX: rd_val = evt_q;
      tsi_pkg::MASK_IDX: rd_val = mask_q;
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
    case (rst_q)
      tsi_pkg::BUS_IDLE: begin
        if (arvalid) begin
          arready_d = 1'b1;
          rst_d = tsi_pkg::BUS_ACC;
        end
      end
      tsi_pkg::BUS_ACC: begin
        rvalid_d = 1'b1;
        rdata_d = {24'h000000, rd_val};
        rresp_d = rd_hit ? tsi_pkg::RESP_OKAY : tsi_pkg::RESP_DECERR;
        rst_d = tsi_pkg::BUS_RESP;
      end
      tsi_pkg::BUS_RESP: begin
        if (rready) begin
          rvalid_d = 1'b0;
          rst_d = tsi_pkg::BUS_IDLE;
        end
      end
      default: rst_d = tsi_pkg::BUS_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers, flags, global enable and vectoring
  always_comb begin
    wbyte = wdata[7:0];
    src_set = 8'h00;
    src_set[tsi_pkg::EXT_BIT] = ext_evt;
    src_set[tsi_pkg::TA_BIT] = timer_a_ovf;
    src_set[tsi_pkg::TB_BIT] = timer_b_ovf;
    // pending only when globally and locally enabled
    take = core_in.boundary && stack_pointer_global_enable_q[tsi_pkg::GIE_BIT] &&
      (|(flag_q & en_q & tsi_pkg::SRC_MASK));
    edge_d = edge_q;
    en_d = en_q;
    flag_d = flag_q;
    stack_pointer_global_enable_d = stack_pointer_global_enable_q;
    mask_d = mask_q;
    evt_d = evt_q;
    if (do_write) begin
      case (wr_idx)
        tsi_pkg::EDGE_IDX: edge_d = wbyte & tsi_pkg::EDGE_MASK;
        tsi_pkg::EN_IDX: en_d = wbyte & tsi_pkg::SRC_MASK;
        tsi_pkg::FLAG_IDX: flag_d = wbyte & tsi_pkg::SRC_MASK;
        tsi_pkg::STACK_POINTER_GLOBAL_ENABLE_IDX: stack_pointer_global_enable_d = wbyte & tsi_pkg::STACK_POINTER_GLOBAL_ENABLE_MASK;
        tsi_pkg::MASK_IDX: mask_d = wbyte & tsi_pkg::EVT_MASK;
        tsi_pkg::EVT_IDX: evt_d = evt_q & ~wbyte;
        default: ;
      endcase
    end
    // a source event beats a software clear in the same cycle; flags are
    // never cleared by vectoring or return, software owns that
    flag_d = flag_d | src_set;
    stk_lvl = stack_pointer_global_enable_q[2:0];
    if (take) begin
      stack_pointer_global_enable_d[tsi_pkg::GIE_BIT] = 1'b0;
      stack_pointer_global_enable_d[2:0] = stk_lvl - 3'h1;
    end else if (core_in.return_from_irq) begin
      stack_pointer_global_enable_d[tsi_pkg::GIE_BIT] = 1'b1;
      stack_pointer_global_enable_d[2:0] = stk_lvl + 3'h1;
    end
    core_d.take = take;
    core_d.vec_pc = take ? tsi_pkg::VECTOR_PC : core_q.vec_pc;
    core_d.ret_pc = take ? core_in.next_pc : core_q.ret_pc;
    wake_d = ext_evt && power_down;
    evt_d[tsi_pkg::EVT_TAKE] = evt_d[tsi_pkg::EVT_TAKE] | take;
    evt_d[tsi_pkg::EVT_WAKE] = evt_d[tsi_pkg::EVT_WAKE] | wake_d;
    evt_d[tsi_pkg::EVT_RET] = evt_d[tsi_pkg::EVT_RET] |
      (core_in.return_from_irq && !take);
    // level interrupt follows the status it will hold next cycle
    irq_d = |(evt_d & mask_d);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_q <= tsi_pkg::BUS_IDLE;
      rst_q <= tsi_pkg::BUS_IDLE;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= tsi_pkg::RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= tsi_pkg::RESP_OKAY;
      edge_q <= tsi_pkg::EDGE_RESET;
      flag_q <= 8'h00;
      en_q <= 8'h00;
      stack_pointer_global_enable_q <= tsi_pkg::STACK_POINTER_GLOBAL_ENABLE_RESET;
      evt_q <= 8'h00;
      mask_q <= 8'h00;
      core_q <= '0;
      wake_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      wst_q <= wst_d;
      rst_q <= rst_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      edge_q <= edge_d;
      flag_q <= flag_d;
      en_q <= en_d;
      stack_pointer_global_enable_q <= stack_pointer_global_enable_d;
      evt_q <= evt_d;
      mask_q <= mask_d;
      core_q <= core_d;
      wake_q <= wake_d;
      irq_q <= irq_d;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign core_out = core_q;
  assign wake_req = wake_q;
  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_GIE_CLR: assert property (core_q.take |->
    !stack_pointer_global_enable_q[tsi_pkg::GIE_BIT] && !$past(core_q.take))
    else $error("global enable not cleared on take");
  AST_GIE_SET: assert property (
    core_in.return_from_irq && !take |=> stack_pointer_global_enable_q[tsi_pkg::GIE_BIT])
    else $error("global enable not restored on return");
  AST_RET_POP: assert property (
    core_in.return_from_irq && !take |=> stack_pointer_global_enable_q[2:0] == $past(stack_pointer_global_enable_q[2:0]) + 3'h1)
    else $error("stack level not popped on return");
  AST_VEC_PUSH: assert property (core_q.take |->
    core_q.vec_pc == tsi_pkg::VECTOR_PC &&
    stack_pointer_global_enable_q[2:0] == $past(stack_pointer_global_enable_q[2:0]) - 3'h1)
    else $error("vector or stack push wrong");
  AST_QUALIFY: assert property (core_q.take |->
    $past(stack_pointer_global_enable_q[tsi_pkg::GIE_BIT] && (|(flag_q & en_q))))
    else $error("vector without qualified request");
  AST_DISABLED: assert property (
    !(|(flag_q & en_q)) |=> !core_q.take)
    else $error("vector for disabled source");
  AST_EXT_SET: assert property (ext_evt |=>
    flag_q[tsi_pkg::EXT_BIT])
    else $error("pin flag not set");
  AST_TA_SET: assert property (timer_a_ovf |=>
    flag_q[tsi_pkg::TA_BIT])
    else $error("timer a flag not set");
  AST_TB_SET: assert property (timer_b_ovf |=>
    flag_q[tsi_pkg::TB_BIT])
    else $error("timer b flag not set");
  AST_RET_ADDR: assert property (core_q.take |->
    $past(core_in.boundary) && core_q.ret_pc == $past(core_in.next_pc))
    else $error("wrong return address");
  AST_WAKE: assert property (ext_evt && power_down |=>
    wake_q)
    else $error("no wake on pin event");
  AST_WAKE_ONLY: assert property (wake_q |->
    $past(ext_evt && power_down))
    else $error("wake without pin event in power-down");
  // flags only fall through a software write, never through vectoring
  AST_NO_HW_CLR: assert property (
    !(do_write && wr_idx == tsi_pkg::FLAG_IDX) |=>
    (flag_q & $past(flag_q)) == $past(flag_q))
    else $error("flag cleared without software write");
  AST_EDGE_SEL: assert property (ext_evt |->
    edge_q[tsi_pkg::EDGE_LSB +: 2] != 2'h0)
    else $error("pin event under reserved edge code");
  // the level output must line up with the status it was computed from
  AST_IRQ_LVL: assert property (irq_q == |(evt_q & mask_q))
    else $error("interrupt level disagrees with status and mask");
  // an answer stands until the master takes it, or a stalled master
  // would read a value that changed under it
  AST_B_HOLD: assert property (bvalid_q && !bready |=>
    bvalid_q && $stable(bresp_q))
    else $error("write response dropped before bready");
  AST_R_HOLD: assert property (rvalid_q && !rready |=>
    rvalid_q && $stable(rdata_q) && $stable(rresp_q))
    else $error("read data dropped before rready");

  COV_TAKE: cover property (core_q.take ##[1:50] core_in.return_from_irq);
  COV_WAKE: cover property (wake_q);
  COV_DECERR: cover property (bvalid_q && bresp_q == tsi_pkg::RESP_DECERR);
  COV_IRQ: cover property ($rose(irq_q));
  COV_NOSTORE: cover property (wst_q == tsi_pkg::BUS_ACC && !wstrb[0]);

endmodule

/* File: test/tsi_core_model.sv */
// core sequencer and timer b counter standing behind the interrupt unit
module tsi_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic step_go,
  input wire logic return_from_irq_go,
  input wire logic [9:0] pc,
  input wire logic run_b,
  output tsi_pkg::tsi_core_in_type core_in,
  output logic timer_b_ovf
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] count_q;
  logic [7:0] count_d;
  tsi_pkg::tsi_core_in_type core_d;
  logic ovf_d;

  ////////////////////////////////////////////////////////////////////////
  // a boundary or return is a single cycle, never held, like the real core
  always_comb begin
    core_d.boundary = step_go;
    core_d.next_pc = pc; // address after the current instruction
    core_d.return_from_irq = return_from_irq_go; // return ends service
    count_d = run_b ? count_q + 8'h01 : count_q;
    ovf_d = run_b && (count_q == 8'hFF); // wrap from FF to 00
  end

  // registered so that requests leave just after a clock edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_in <= '0;
      count_q <= 8'h00;
      timer_b_ovf <= 1'b0;
    end else begin
      core_in <= core_d;
      count_q <= count_d;
      timer_b_ovf <= ovf_d;
    end
  end
endmodule

/* File: test/test_three_source_interrupt_unit.sv */
module test_three_source_interrupt_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, seed = 32'h3F;
  logic [1:0] bresp, rresp;
  logic [3:0] wstrb = 4'hF;
  logic timer_a_ovf = 0, timer_b_ovf, ext_irq_pin = 0, power_down = 0;
  logic step_go = 0, return_from_irq_go = 0, run_b = 0, wake_req, irq;
  logic [9:0] pc = 10'h000;
  tsi_pkg::tsi_core_in_type core_in;
  tsi_pkg::tsi_core_out_type core_out;
  logic [33:0] bq[$], rq[$], tq[$];
  int n_fail = 0, n_checks = 0, n_wake = 0;

  always #10 aclk = ~aclk;

  tsi_unit i_tsi_unit (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .timer_a_ovf(timer_a_ovf),
    .timer_b_ovf(timer_b_ovf), .ext_irq_pin(ext_irq_pin),
    .power_down(power_down), .core_in(core_in), .core_out(core_out),
    .wake_req(wake_req), .irq(irq));

  tsi_core_model i_tsi_core_model (.aclk(aclk), .aresetn(aresetn),
    .step_go(step_go), .return_from_irq_go(return_from_irq_go), .pc(pc), .run_b(run_b),
    .core_in(core_in), .timer_b_ovf(timer_b_ovf));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string what, input logic [33:0] got,
                     input logic [33:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got,
               exp);
    end
  endtask

  // one compare task per kind of result; all share the tally above
  task automatic chk_resp(input logic [33:0] got, input logic [33:0] exp);
    chk("write response", got, exp);
  endtask

  task automatic chk_read(input logic [33:0] got, input logic [33:0] exp);
    chk("read data", got, exp);
  endtask

  task automatic chk_vec(input logic [33:0] got, input logic [33:0] exp);
    chk("vector", got, exp);
  endtask

  task automatic chk_lvl(input logic [33:0] got, input logic [33:0] exp);
    chk("level or count", got, exp);
  endtask

  task automatic finish_test();
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // bus master: hold each request until its ready, then release
  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    input logic [1:0] resp);
    logic aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    bq.push_back({32'h0, resp});
    @(posedge aclk);
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {24'h0, d};
    // each channel is released at the edge that takes it, not before
    do begin
      @(posedge aclk);
      if (awready === 1'b1) aw_done = 1;
      if (wready === 1'b1) w_done = 1;
      if (aw_done) awvalid <= 0;
      if (w_done) wvalid <= 0;
    end while (!(aw_done && w_done));
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 0;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] d,
                    input logic [1:0] resp);
    rq.push_back({resp, 24'h0, d});
    @(posedge aclk);
    arvalid <= 1;
    rready <= 1;
    araddr <= {2'h0, idx, 2'h0};
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 0;
  endtask

  // one instruction boundary, then a fixed wait of four cycles
  task automatic step(input logic take);
    logic [9:0] p;
    p = 10'(rnd()); // random return address reaches next_pc
    if (take) tq.push_back({14'h0, tsi_pkg::VECTOR_PC, p});
    @(posedge aclk);
    step_go <= 1;
    pc <= p;
    @(posedge aclk);
    step_go <= 0;
    repeat (4) @(posedge aclk);
  endtask

  task automatic ret();
    @(posedge aclk);
    return_from_irq_go <= 1;
    @(posedge aclk);
    return_from_irq_go <= 0;
    repeat (3) @(posedge aclk);
  endtask

  task automatic pin(input logic v);
    @(posedge aclk);
    ext_irq_pin <= v;
    repeat (6) @(posedge aclk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // results are taken off the queues in the order they were noted
  always @(posedge aclk) begin
    if (bvalid && bready) chk_resp({32'h0, bresp}, bq.pop_front());
    if (rvalid && rready) chk_read({rresp, rdata}, rq.pop_front());
    if (core_out.take === 1'b1) begin
      if (tq.size() == 0) chk_vec(34'h1, 34'h0);
      else chk_vec({14'h0, core_out.vec_pc, core_out.ret_pc},
                   tq.pop_front());
    end
    if (wake_req === 1'b1) n_wake++;
  end

  // watchdog sized well above the few hundred cycles of the run
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    finish_test();
  end

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    repeat (3) @(posedge aclk);
    rd(tsi_pkg::EDGE_IDX, 8'h10, 2'h0);
    rd(tsi_pkg::FLAG_IDX, 8'h00, 2'h0);
    rd(tsi_pkg::EN_IDX, 8'h00, 2'h0);
    rd(tsi_pkg::STACK_POINTER_GLOBAL_ENABLE_IDX, 8'h07, 2'h0);
    rd(8'h10, 8'h00, tsi_pkg::RESP_DECERR);
    wr(8'h10, 8'h55, tsi_pkg::RESP_DECERR);
    wr(tsi_pkg::STACK_POINTER_GLOBAL_ENABLE_IDX, 8'h87, 2'h0);
    @(posedge aclk);
    timer_a_ovf <= 1;
    @(posedge aclk);
    timer_a_ovf <= 0;
    step(0);
    rd(tsi_pkg::FLAG_IDX, 8'h10, 2'h0);
    run_b <= 1;
    repeat (300) @(posedge aclk);
    run_b <= 0;
    rd(tsi_pkg::FLAG_IDX, 8'h30, 2'h0);
    wr(tsi_pkg::FLAG_IDX, 8'h00, 2'h0);
    wr(tsi_pkg::EN_IDX, 8'hFF, 2'h0);
    rd(tsi_pkg::EN_IDX, 8'h31, 2'h0);
    wstrb <= 4'hE; // low lane off: answered but nothing stored
    wr(tsi_pkg::EN_IDX, 8'h00, 2'h0);
    wstrb <= 4'hF;
    rd(tsi_pkg::EN_IDX, 8'h31, 2'h0);
    wr(tsi_pkg::FLAG_IDX, 8'h20, 2'h0);
    for (int k = 0; k < 2; k++) begin
      step(1);
      rd(tsi_pkg::STACK_POINTER_GLOBAL_ENABLE_IDX, 8'h06, 2'h0);
      step(0);
      // service routine polls enables, then flags, in its own order
      rd(tsi_pkg::EN_IDX, 8'h31, 2'h0);
      rd(tsi_pkg::FLAG_IDX, 8'h20, 2'h0);
      ret();
      rd(tsi_pkg::STACK_POINTER_GLOBAL_ENABLE_IDX, 8'h87, 2'h0);
    end
    wr(tsi_pkg::STACK_POINTER_GLOBAL_ENABLE_IDX, 8'h07, 2'h0);
    step(0);
    rd(tsi_pkg::EVT_IDX, 8'h05, 2'h0);
    wr(tsi_pkg::MASK_IDX, 8'h01, 2'h0);
    repeat (2) @(posedge aclk);
    chk_lvl({33'h0, irq}, 34'h1);
    wr(tsi_pkg::EVT_IDX, 8'h07, 2'h0);
    repeat (2) @(posedge aclk);
    chk_lvl({33'h0, irq}, 34'h0);
    // every edge code, the reserved one included, with both pin edges
    for (int c = 0; c < 4; c++) begin
      wr(tsi_pkg::EDGE_IDX, {3'h0, c[1:0], 3'h0}, 2'h0);
      wr(tsi_pkg::FLAG_IDX, 8'h00, 2'h0);
      pin(1);
      rd(tsi_pkg::FLAG_IDX, {7'h0, c[0]}, 2'h0);
      wr(tsi_pkg::FLAG_IDX, 8'h00, 2'h0);
      pin(0);
      rd(tsi_pkg::FLAG_IDX, {7'h0, c[1]}, 2'h0);
    end
    power_down <= 1;
    pin(1);
    power_down <= 0;
    rd(tsi_pkg::EVT_IDX, 8'h02, 2'h0);
    chk_lvl(34'(n_wake), 34'h1);
    chk_lvl(34'(tq.size()), 34'h0);
    finish_test();
  end
endmodule
